// ### svi_status_indicator.sv
// Status indicator bits and status code for a servo drive panel.
// Assumes drive-core inputs synchronous to pclk; registers over APB.
// Notes on behaviour
// - Control power bit follows control power
// - Base-block bit lit unless servo on
// - Speed mode: lit when speed meets reference
// - Rotation bit lit above rotation level
// - Speed mode: speed reference above rotation level
// - Speed mode: torque reference above torque level
// - Power-ready bit follows main circuit normal
// - Position mode: lit when error below window
// - Position mode: lit while reference pulses arrive
// - Position mode: lit while counter clear asserted
// - Base-block code when servo off
// - Run code when servo on
// - Forward prohibited code, gated by bit 2
// - Reverse prohibited code, gated by bit 3
// - Alarm code carries alarm number
//
// Design decisions made here: the register offsets and register access over APB.
`timescale 1ns/100ps
`default_nettype none
module svi_status_indicator #(
	parameter int PULSE_HOLD = svi_pkg::PULSE_HOLD_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic ctrl_power_on,
	input wire logic servo_on,
	input wire logic main_power_ok,
	input wire logic signed [15:0] motor_speed,
	input wire logic signed [15:0] speed_reference,
	input wire logic signed [15:0] torque_reference,
	input wire logic signed [15:0] position_error,
	input wire logic reference_pulse,
	input wire logic counter_clear_input,
	input wire logic forward_overtravel_input,
	input wire logic reverse_overtravel_input,
	input wire logic alarm_active,
	input wire logic [7:0] alarm_number,
	output logic [6:0] indicator_bits,
	output logic [4:0] status_code,
	output logic [7:0] status_alarm_number,
	output logic position_mode
);
	localparam int PH_W = $clog2(PULSE_HOLD + 1);
	localparam logic [PH_W-1:0] PH_LOAD = PH_W'(PULSE_HOLD);

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic [15:0] rot_level;
		logic [15:0] torq_level;
		logic [15:0] pos_window;
		logic [15:0] func_sel;
		logic [15:0] spd_band;
		logic pos_mode;
		logic [6:0] ind;
		svi_pkg::svi_code_t code;
		logic [7:0] alarm_num;
		logic [PH_W-1:0] pulse_cnt;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} svi_state_t;

	svi_state_t q;
	svi_state_t d;

	function automatic logic [15:0] mag16(input logic signed [15:0] v);
		mag16 = v[15] ? 16'(-v) : 16'(v);
	endfunction : mag16

	function automatic logic reg_hit(input logic [7:0] a);
		reg_hit = (a == svi_pkg::OFS_CTRL) || (a == svi_pkg::OFS_ROT_LEVEL) ||
			(a == svi_pkg::OFS_TORQ_LEVEL) || (a == svi_pkg::OFS_POS_WINDOW) ||
			(a == svi_pkg::OFS_FUNC_SEL1) || (a == svi_pkg::OFS_SPD_BAND) ||
			(a == svi_pkg::OFS_STATUS);
	endfunction : reg_hit

	logic [15:0] spd_mag;
	logic [15:0] sref_mag;
	logic [15:0] tref_mag;
	logic [15:0] err_mag;
	logic [15:0] diff_mag;
	logic fwd_block;
	logic rev_block;
	logic apb_commit;

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		d = q;
		spd_mag = mag16(motor_speed);
		sref_mag = mag16(speed_reference);
		tref_mag = mag16(torque_reference);
		err_mag = mag16(position_error);
		diff_mag = mag16(16'(motor_speed - speed_reference));
		fwd_block = !forward_overtravel_input && !q.func_sel[svi_pkg::FS_FWD_IGNORE];
		rev_block = !reverse_overtravel_input && !q.func_sel[svi_pkg::FS_REV_IGNORE];
		apb_commit = psel && penable && q.pready;

		// Reference pulse activity window
		if (reference_pulse) begin
			d.pulse_cnt = PH_LOAD;
		end else if (q.pulse_cnt != '0) begin
			d.pulse_cnt = q.pulse_cnt - PH_W'(1);
		end

		d.ind[svi_pkg::IND_CTRL_PWR] = ctrl_power_on;
		d.ind[svi_pkg::IND_BASE_BLK] = !servo_on;
		d.ind[svi_pkg::IND_ROT] = spd_mag > q.rot_level;
		d.ind[svi_pkg::IND_PWR_RDY] = main_power_ok;
		if (q.pos_mode) begin
			d.ind[svi_pkg::IND_COINC_DONE] = err_mag < q.pos_window;
			d.ind[svi_pkg::IND_REF_A] = reference_pulse || (q.pulse_cnt != '0);
			d.ind[svi_pkg::IND_REF_B] = counter_clear_input;
		end else begin
			d.ind[svi_pkg::IND_COINC_DONE] = diff_mag <= q.spd_band;
			d.ind[svi_pkg::IND_REF_A] = sref_mag > q.rot_level;
			d.ind[svi_pkg::IND_REF_B] = tref_mag > q.torq_level;
		end

		// Fixed priority status code
		d.alarm_num = 8'h00;
		if (alarm_active) begin
			d.code = svi_pkg::SVI_CODE_ALARM;
			d.alarm_num = alarm_number;
		end else if (fwd_block) begin
			d.code = svi_pkg::SVI_CODE_FWD;
		end else if (rev_block) begin
			d.code = svi_pkg::SVI_CODE_REV;
		end else if (servo_on) begin
			d.code = svi_pkg::SVI_CODE_RUN;
		end else begin
			d.code = svi_pkg::SVI_CODE_BASE;
		end

		// ****************************************
		// APB slave: one wait state
		// ****************************************
		d.pready = psel && penable && !q.pready;
		if (psel && penable && !q.pready) begin
			d.pslverr = !reg_hit(paddr);
			d.prdata = 32'h0000_0000;
			if (!pwrite) begin
				case (paddr)
					svi_pkg::OFS_CTRL: d.prdata = {31'h0000_0000, q.pos_mode};
					svi_pkg::OFS_ROT_LEVEL: d.prdata = {16'h0000, q.rot_level};
					svi_pkg::OFS_TORQ_LEVEL: d.prdata = {16'h0000, q.torq_level};
					svi_pkg::OFS_POS_WINDOW: d.prdata = {16'h0000, q.pos_window};
					svi_pkg::OFS_FUNC_SEL1: d.prdata = {16'h0000, q.func_sel};
					svi_pkg::OFS_SPD_BAND: d.prdata = {16'h0000, q.spd_band};
					svi_pkg::OFS_STATUS: d.prdata = {8'h00, q.alarm_num, 3'h0, q.code,
						1'h0, q.ind};
					default: d.prdata = 32'h0000_0000;
				endcase
			end
		end else begin
			d.pslverr = 1'b0;
		end
		if (apb_commit && pwrite) begin
			case (paddr)
				svi_pkg::OFS_CTRL: d.pos_mode = pwdata[svi_pkg::CTRL_POS_MODE];
				svi_pkg::OFS_ROT_LEVEL: d.rot_level = pwdata[15:0];
				svi_pkg::OFS_TORQ_LEVEL: d.torq_level = pwdata[15:0];
				svi_pkg::OFS_POS_WINDOW: d.pos_window = pwdata[15:0];
				svi_pkg::OFS_FUNC_SEL1: d.func_sel = pwdata[15:0];
				svi_pkg::OFS_SPD_BAND: d.spd_band = pwdata[15:0];
				default: d.pos_mode = q.pos_mode;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q.rot_level <= svi_pkg::RST_ROT_LEVEL;
			q.torq_level <= svi_pkg::RST_TORQ_LEVEL;
			q.pos_window <= svi_pkg::RST_POS_WINDOW;
			q.func_sel <= svi_pkg::RST_FUNC_SEL1;
			q.spd_band <= svi_pkg::RST_SPD_BAND;
			q.pos_mode <= 1'b0;
			q.ind <= 7'h00;
			q.code <= svi_pkg::SVI_CODE_BASE;
			q.alarm_num <= 8'h00;
			q.pulse_cnt <= '0;
			q.pready <= 1'b0;
			q.pslverr <= 1'b0;
			q.prdata <= 32'h0000_0000;
		end else begin
			q <= d;
		end
	end

	assign prdata = q.prdata;
	assign pready = q.pready;
	assign pslverr = q.pslverr;
	assign indicator_bits = q.ind;
	assign status_code = q.code;
	assign status_alarm_number = q.alarm_num;
	assign position_mode = q.pos_mode;

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_alarm_in;
		alarm_active;
	endsequence
	sequence s_alarm_out;
		q.code == svi_pkg::SVI_CODE_ALARM && q.alarm_num == $past(alarm_number);
	endsequence
	sequence s_pulse_seen;
		q.pos_mode && reference_pulse && !$past(psel);
	endsequence

	AST_CTRL_PWR: assert property (ctrl_power_on |=> q.ind[0] ##1 1'b1)
		else $error("control power bit not lit");
	AST_BASE_BLK: assert property (servo_on |=> !q.ind[1] && q.code != svi_pkg::SVI_CODE_BASE)
		else $error("base block bit lit while servo on");
	AST_COINC: assert property (!q.pos_mode && !(psel && penable && q.pready)
		&& mag16(16'(motor_speed - speed_reference)) > q.spd_band |=> !q.ind[2])
		else $error("speed coincidence lit off reference");
	AST_COINC_ON: assert property (!q.pos_mode && !(psel && penable && q.pready)
		&& mag16(16'(motor_speed - speed_reference)) <= q.spd_band |=> q.ind[2])
		else $error("speed coincidence not lit at reference");
	AST_ROT: assert property (1'b1 |=>
		q.ind[3] == (mag16($past(motor_speed)) > $past(q.rot_level)))
		else $error("rotation bit disagrees with level");
	AST_SREF: assert property (!q.pos_mode && !(psel && penable && q.pready)
		&& mag16(speed_reference) > q.rot_level |=> q.ind[4])
		else $error("speed reference bit not lit");
	AST_SREF_OFF: assert property (!q.pos_mode && !(psel && penable && q.pready)
		&& mag16(speed_reference) <= q.rot_level |=> !q.ind[4])
		else $error("speed reference bit lit below level");
	AST_TREF: assert property (!q.pos_mode && !(psel && penable && q.pready)
		&& mag16(torque_reference) <= q.torq_level |=> !q.ind[5])
		else $error("torque reference bit lit below level");
	AST_TREF_ON: assert property (!q.pos_mode && !(psel && penable && q.pready)
		&& mag16(torque_reference) > q.torq_level |=> q.ind[5])
		else $error("torque reference bit not lit above level");
	AST_PWR_RDY: assert property (!main_power_ok |=> !q.ind[6])
		else $error("power ready lit with main power off");
	AST_PWR_RDY_ON: assert property (main_power_ok |=> q.ind[6])
		else $error("power ready not lit with main power normal");
	AST_POS_DONE: assert property (q.pos_mode && !(psel && penable && q.pready)
		&& mag16(position_error) >= q.pos_window |=> !q.ind[2])
		else $error("positioning complete lit outside window");
	AST_POS_DONE_ON: assert property (q.pos_mode && !(psel && penable && q.pready)
		&& mag16(position_error) < q.pos_window |=> q.ind[2])
		else $error("positioning complete not lit inside window");
	AST_PULSE: assert property (s_pulse_seen |=> q.ind[4] [*3])
		else $error("reference pulse bit not held");
	AST_PULSE_OFF: assert property (q.pos_mode && !(psel && penable && q.pready)
		&& !reference_pulse && q.pulse_cnt == '0 |=> !q.ind[4])
		else $error("reference pulse bit lit with no pulse");
	AST_CLR: assert property (q.pos_mode && !(psel && penable && q.pready)
		&& counter_clear_input |=> q.ind[5])
		else $error("counter clear bit not lit");
	AST_CLR_OFF: assert property (q.pos_mode && !(psel && penable && q.pready)
		&& !counter_clear_input |=> !q.ind[5])
		else $error("counter clear bit lit without clear");
	AST_ALARM: assert property (s_alarm_in |=> s_alarm_out)
		else $error("alarm code or number wrong");
	AST_ALARM_CLEAR: assert property (!alarm_active |=> q.alarm_num == 8'h00)
		else $error("alarm number shown without alarm");
	AST_FWD: assert property (!alarm_active && !forward_overtravel_input
		&& !q.func_sel[2] && !(psel && penable && q.pready)
		|=> q.code == svi_pkg::SVI_CODE_FWD)
		else $error("forward prohibited code missing");
	AST_REV: assert property (!alarm_active && forward_overtravel_input
		&& !reverse_overtravel_input && !q.func_sel[3] && !(psel && penable && q.pready)
		|=> q.code == svi_pkg::SVI_CODE_REV)
		else $error("reverse prohibited code missing");
	AST_RUN_BASE: assert property (!alarm_active && forward_overtravel_input
		&& reverse_overtravel_input |=> q.code == ($past(servo_on) ? svi_pkg::SVI_CODE_RUN
		: svi_pkg::SVI_CODE_BASE))
		else $error("run or base block code wrong");
	AST_RUN: assert property (!alarm_active && forward_overtravel_input
		&& reverse_overtravel_input && servo_on |=> q.code == svi_pkg::SVI_CODE_RUN)
		else $error("run code missing with servo on");
	AST_BASE_CODE: assert property (!alarm_active && forward_overtravel_input
		&& reverse_overtravel_input && !servo_on |=> q.code == svi_pkg::SVI_CODE_BASE)
		else $error("base block code missing with servo off");

	// ****************************************
	// Bus answer
	// ****************************************
	AST_APB_WAIT: assert property (psel && penable && !q.pready |=> q.pready ##1 !q.pready)
		else $error("apb answer timing wrong");
	AST_APB_ERR: assert property (q.pslverr |-> q.pready)
		else $error("bus error without ready");
endmodule : svi_status_indicator
`default_nettype wire

// ### svi_pkg.sv
// Constants for the servo status indicator block.
// Assumes a 20 MHz APB clock and a single reset domain.
package svi_pkg;
	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_MHZ = 20;
	localparam int PULSE_HOLD_US = 1000;
	localparam int PULSE_HOLD_CYC = PULSE_HOLD_US * CLK_MHZ;

	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_ROT_LEVEL = 8'h04;
	localparam logic [7:0] OFS_TORQ_LEVEL = 8'h08;
	localparam logic [7:0] OFS_POS_WINDOW = 8'h0c;
	localparam logic [7:0] OFS_FUNC_SEL1 = 8'h10;
	localparam logic [7:0] OFS_SPD_BAND = 8'h14;
	localparam logic [7:0] OFS_STATUS = 8'h18;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [15:0] RST_ROT_LEVEL = 16'h0014;
	localparam logic [15:0] RST_TORQ_LEVEL = 16'h000a;
	localparam logic [15:0] RST_POS_WINDOW = 16'h0001;
	localparam logic [15:0] RST_FUNC_SEL1 = 16'h0000;
	localparam logic [15:0] RST_SPD_BAND = 16'h000a;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int CTRL_POS_MODE = 0;
	localparam int FS_FWD_IGNORE = 2;
	localparam int FS_REV_IGNORE = 3;
	localparam int IND_CTRL_PWR = 0;
	localparam int IND_BASE_BLK = 1;
	localparam int IND_COINC_DONE = 2;
	localparam int IND_ROT = 3;
	localparam int IND_REF_A = 4;
	localparam int IND_REF_B = 5;
	localparam int IND_PWR_RDY = 6;
	localparam int IND_W = 7;
	localparam int ST_CODE_LSB = 8;
	localparam int ST_ALM_LSB = 16;

	// ****************************************
	// Status codes, one-hot
	// ****************************************
	typedef enum logic [4:0] {
		SVI_CODE_BASE = 5'h01,
		SVI_CODE_RUN = 5'h02,
		SVI_CODE_FWD = 5'h04,
		SVI_CODE_REV = 5'h08,
		SVI_CODE_ALARM = 5'h10
	} svi_code_t;
endpackage : svi_pkg

// ### svi_core_model.sv
// Drive core model: status levels and a reference pulse train.
// Assumes the bench loads levels through num, fl and an.
`timescale 1ns/100ps
`default_nettype none
module svi_core_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [63:0] num,
	input wire logic [7:0] fl,
	input wire logic [7:0] an,
	output logic ctrl_power_on,
	output logic servo_on,
	output logic main_power_ok,
	output logic signed [15:0] motor_speed,
	output logic signed [15:0] speed_reference,
	output logic signed [15:0] torque_reference,
	output logic signed [15:0] position_error,
	output logic reference_pulse,
	output logic counter_clear_input,
	output logic forward_overtravel_input,
	output logic reverse_overtravel_input,
	output logic alarm_active,
	output logic [7:0] alarm_number
);
	logic [1:0] ph;
	// *****
	// Pulses every third cycle while enabled
	// *****
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{motor_speed, speed_reference, torque_reference, position_error} <= '0;
			{ctrl_power_on, servo_on, main_power_ok, counter_clear_input} <= '0;
			{forward_overtravel_input, reverse_overtravel_input, alarm_active} <= '0;
			{reference_pulse, alarm_number, ph} <= '0;
		end else begin
			ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
			{motor_speed, speed_reference, torque_reference, position_error} <= num;
			{ctrl_power_on, servo_on, main_power_ok, counter_clear_input} <= fl[6:3];
			{forward_overtravel_input, reverse_overtravel_input, alarm_active} <= fl[2:0];
			reference_pulse <= fl[7] && ph == 2'h0;
			alarm_number <= an;
		end
	end
endmodule : svi_core_model
`default_nettype wire

// ### tb_top.sv
// Self-checking bench for the status indicator block.
// Assumes the core model drives the status inputs.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic pclk, presetn, psel, penable, pwrite, pm;
	logic [7:0] paddr, an, fl, fr;
	logic [31:0] pwdata, prdata, rd;
	logic pready, pslverr, er, position_mode;
	logic [6:0] indicator_bits;
	logic [4:0] status_code;
	logic [7:0] status_alarm_number;
	logic ctrl_power_on, servo_on, main_power_ok, reference_pulse;
	logic counter_clear_input, forward_overtravel_input, reverse_overtravel_input;
	logic alarm_active;
	logic [7:0] alarm_number;
	logic signed [15:0] motor_speed, speed_reference, torque_reference, position_error;
	logic [63:0] num;
	logic [3:0] fs;
	int miscompares, tests_run, seed, rot, tql, win, band;
	svi_status_indicator #(.PULSE_HOLD(8)) i_svi_status_indicator (.*);
	svi_core_model i_svi_core_model (.*);
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	// *****
	// Expectations
	// *****
	function automatic int ab(input int v);
		return v < 0 ? -v : v;
	endfunction : ab
	function automatic logic [15:0] rn();
		return 16'(($random(seed) & 63) - 32);
	endfunction : rn
	function automatic logic [6:0] xind();
		int s, r, t, e;
		logic [6:0] b;
		s = int'($signed(num[63:48]));
		r = int'($signed(num[47:32]));
		t = int'($signed(num[31:16]));
		e = int'($signed(num[15:0]));
		b[0] = fl[6];
		b[1] = !fl[5];
		b[3] = ab(s) > rot;
		b[6] = fl[4];
		b[2] = pm ? ab(e) < win : ab(s - r) <= band;
		b[4] = pm ? fl[7] : ab(r) > rot;
		b[5] = pm ? fl[3] : ab(t) > tql;
		return b;
	endfunction : xind
	function automatic logic [4:0] xcode();
		if (fl[0]) return svi_pkg::SVI_CODE_ALARM;
		if (!fl[2] && !fs[2]) return svi_pkg::SVI_CODE_FWD;
		if (!fl[1] && !fs[3]) return svi_pkg::SVI_CODE_REV;
		return fl[5] ? svi_pkg::SVI_CODE_RUN : svi_pkg::SVI_CODE_BASE;
	endfunction : xcode
	// *****
	// Bus and compare tasks
	// *****
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic ee);
		apb(1'b0, a, 32'h0);
		chk(rd, e);
		chk(32'(er), 32'(ee));
	endtask : rdc
	task automatic vec();
		logic [7:0] ea;
		repeat (16) @(posedge pclk);
		ea = fl[0] ? an : 8'h00;
		chk(32'(indicator_bits), 32'(xind()));
		chk(32'(status_code), 32'(xcode()));
		chk(32'(status_alarm_number), 32'(ea));
		rdc(svi_pkg::OFS_STATUS, {8'h00, ea, 3'h0, xcode(), 1'b0, xind()}, 1'b0);
	endtask : vec
	task automatic end_sim();
		$display("compares %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : end_sim
	initial begin
		#1000000;
		miscompares++;
		$display("watchdog expired");
		end_sim();
	end
	// *****
	// Main sequence
	// *****
	initial begin
		seed = 32'h6180;
		{presetn, psel, penable, pwrite, paddr, pwdata, num, fl, an, fs, pm} = '0;
		{rot, tql, win, band} = {32'd20, 32'd10, 32'd1, 32'd10};
		repeat (6) @(posedge pclk);
		chk(32'(status_code), 32'(svi_pkg::SVI_CODE_BASE));
		chk(32'(indicator_bits), 32'h0);
		presetn <= 1'b1;
		@(posedge pclk);
		rdc(svi_pkg::OFS_CTRL, 32'h0, 1'b0);
		rdc(svi_pkg::OFS_ROT_LEVEL, 32'(svi_pkg::RST_ROT_LEVEL), 1'b0);
		rdc(svi_pkg::OFS_TORQ_LEVEL, 32'(svi_pkg::RST_TORQ_LEVEL), 1'b0);
		rdc(svi_pkg::OFS_POS_WINDOW, 32'(svi_pkg::RST_POS_WINDOW), 1'b0);
		rdc(svi_pkg::OFS_FUNC_SEL1, 32'(svi_pkg::RST_FUNC_SEL1), 1'b0);
		rdc(svi_pkg::OFS_SPD_BAND, 32'(svi_pkg::RST_SPD_BAND), 1'b0);
		rdc(8'h1c, 32'h0, 1'b1);
		apb(1'b1, 8'h1c, 32'hffffffff);
		chk(32'(er), 32'h1);
		apb(1'b1, svi_pkg::OFS_STATUS, 32'hffffffff);
		chk(32'(er), 32'h0);
		vec();
		$display("test reset values done");
		for (int m = 0; m < 2; m++) begin
			pm = m[0];
			apb(1'b1, svi_pkg::OFS_CTRL, 32'(pm));
			for (int i = 0; i < 40; i++) begin
				rot = ($random(seed) & 15) + 10;
				tql = $random(seed) & 15;
				win = $random(seed) & 3;
				band = $random(seed) & 15;
				fs = 4'($random(seed)) & 4'hc;
				apb(1'b1, svi_pkg::OFS_ROT_LEVEL, 32'(rot));
				apb(1'b1, svi_pkg::OFS_TORQ_LEVEL, 32'(tql));
				apb(1'b1, svi_pkg::OFS_POS_WINDOW, 32'(win));
				apb(1'b1, svi_pkg::OFS_SPD_BAND, 32'(band));
				apb(1'b1, svi_pkg::OFS_FUNC_SEL1, 32'(fs));
				num <= {rn(), rn(), rn(), rn()};
				fr = 8'($random(seed));
				fl <= (i == 0) ? 8'hff : (i == 1) ? 8'h60 : fr;
				an <= 8'($random(seed));
				vec();
				chk(32'(position_mode), 32'(pm));
			end
			$display("test mode %0d done", m);
		end
		fl <= 8'h80;
		repeat (3) @(posedge pclk);
		fl <= 8'h00;
		repeat (3) @(posedge pclk);
		chk(32'(indicator_bits[4]), 32'h1);
		repeat (14) @(posedge pclk);
		chk(32'(indicator_bits[4]), 32'h0);
		$display("test pulse hold done");
		end_sim();
	end
endmodule : tb_top
`default_nettype wire
